// [core/ppc_top.sv]
// Pin control and pin interrupt logic for one port, APB register access
`timescale 1ns/100ps
`include "ppc_map.svh"
module ppc_top #(
  parameter int PINS = 8
) (
  // Clock, reset, enable
  input wire logic I_CLK_SYS,
  input wire logic I_NRST,
  input wire logic I_CE,
  // APB slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [`PPC_ADDR_W-1:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // Pin ownership from port and peripheral logic
  input wire ppc_pkg::ppc_pin_own_t [PINS-1:0] I_PIN_OWN,
  // Pin levels from the pads
  input wire logic [PINS-1:0] I_PIN,
  // Stop mode request from the power controller
  input wire logic I_STOP,
  // Pad control
  output ppc_pkg::ppc_pin_ctrl_t [PINS-1:0] O_PIN_CTRL,
  // Interrupt request and wake
  output logic O_IRQ,
  output logic O_WAKE,
  // Power state
  output logic O_PD_RECOVERED
);

  // Register state
  logic [PINS-1:0] pull_en_r;
  logic [PINS-1:0] slew_en_r;
  logic [PINS-1:0] drive_sel_r;
  logic [PINS-1:0] pin_sel_r;
  logic [PINS-1:0] edge_pol_r;
  logic mode_r;
  logic irq_en_r;
  logic irq_flag_r;
  logic pd_sel_r;
  logic pd_sel_locked_r;
  logic pd_flag_r;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic rd_err_r;
  logic rd_err_nxt;
  ppc_pkg::ppc_pwr_t pwr_r;
  ppc_pkg::ppc_pwr_t pwr_nxt;

  // Detection state
  logic [PINS-1:0] pin_lvl;
  logic [PINS-1:0] armed_r;
  logic [PINS-1:0] active;
  logic [PINS-1:0] edge_hit;
  logic any_level;
  logic flag_set;
  logic flag_clr;

  // Pad control state
  ppc_pkg::ppc_pin_ctrl_t [PINS-1:0] ctrl_r;
  ppc_pkg::ppc_pin_ctrl_t [PINS-1:0] ctrl_nxt;

  // Bus decode
  logic setup_ph;
  logic wr_acc;
  logic ack_wr;
  logic pd_ack_wr;
  logic cfg_wr_ok;
  logic holding;

  // Widen a port-wide field into a bus word
  function automatic logic [31:0] to_word(input logic [PINS-1:0] v);
    logic [31:0] w;
    w = '0;
    w[PINS-1:0] = v;
    return w;
  endfunction

  // True when the offset names a mapped register
  function automatic logic is_mapped(input logic [`PPC_ADDR_W-1:0] a);
    logic hit;
    hit = 1'b0;
    case (a)
      `PPC_OFS_PULL,
      `PPC_OFS_SLEW,
      `PPC_OFS_DRIVE,
      `PPC_OFS_PINSEL,
      `PPC_OFS_EDGE,
      `PPC_OFS_IRQSC,
      `PPC_OFS_PWR,
      `PPC_OFS_PINS: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  // Bus decode
  assign setup_ph = I_PSEL & ~I_PENABLE;
  assign wr_acc = I_CE & I_PSEL & I_PENABLE & I_PWRITE;
  assign ack_wr = wr_acc & (I_PADDR == `PPC_OFS_IRQSC)
                  & I_PWDATA[`PPC_SC_ACK];
  assign pd_ack_wr = wr_acc & (I_PADDR == `PPC_OFS_PWR)
                     & I_PWDATA[`PPC_PW_ACK];
  // Pin latches stay frozen while stopped
  assign holding = (pwr_r != ppc_pkg::PWR_RUN);
  assign cfg_wr_ok = wr_acc & ~holding;

  // Zero wait states; a frozen clock enable stretches the access
  assign O_PREADY = I_CE;
  assign O_PSLVERR = I_PSEL & I_PENABLE & rd_err_r;
  assign O_PRDATA = prdata_r;

  // Pin synchroniser
  ppc_pin_sync #(
    .WIDTH(PINS)
  ) u_sync (
    .i_clk(I_CLK_SYS),
    .i_nrst(I_NRST),
    .i_ce(I_CE),
    .i_pin(I_PIN),
    .o_level(pin_lvl)
  );

  // Configuration registers
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      pull_en_r <= {PINS{`PPC_RST_OFF}};
      slew_en_r <= {PINS{`PPC_RST_SLEW}};
      drive_sel_r <= {PINS{`PPC_RST_OFF}};
      pin_sel_r <= {PINS{`PPC_RST_OFF}};
      edge_pol_r <= {PINS{`PPC_RST_OFF}};
    end else if (I_CE && cfg_wr_ok) begin
      case (I_PADDR)
        `PPC_OFS_PULL: pull_en_r <= I_PWDATA[PINS-1:0];
        `PPC_OFS_SLEW: slew_en_r <= I_PWDATA[PINS-1:0];
        `PPC_OFS_DRIVE: drive_sel_r <= I_PWDATA[PINS-1:0];
        `PPC_OFS_PINSEL: pin_sel_r <= I_PWDATA[PINS-1:0];
        `PPC_OFS_EDGE: edge_pol_r <= I_PWDATA[PINS-1:0];
        default: pin_sel_r <= pin_sel_r;
      endcase
    end
  end

  // Port mode and enable bits
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      mode_r <= 1'b0;
      irq_en_r <= 1'b0;
    end else if (I_CE && cfg_wr_ok && I_PADDR == `PPC_OFS_IRQSC) begin
      mode_r <= I_PWDATA[`PPC_SC_MODE];
      irq_en_r <= I_PWDATA[`PPC_SC_IE];
    end
  end

  // Active level per pin; polarity 1 means high or rising
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      active[i] = pin_sel_r[i]
                  & (edge_pol_r[i] ? pin_lvl[i] : ~pin_lvl[i]);
    end
  end

  // Arm a pin once it is seen deasserted
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      armed_r <= '0;
    end else if (I_CE) begin
      armed_r <= pin_sel_r & ~active;
    end
  end

  // Deasserted one cycle, asserted the next
  assign edge_hit = armed_r & active;
  assign any_level = |active;
  assign flag_set = (|edge_hit)
                    | (mode_r & any_level);
  // Level mode refuses the clear while any pin is still asserted
  assign flag_clr = ack_wr & ~(mode_r & any_level);

  // Port flag: a new event wins over the acknowledge
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      irq_flag_r <= 1'b0;
    end else if (I_CE) begin
      if (flag_set) begin
        irq_flag_r <= 1'b1;
      end else if (flag_clr) begin
        irq_flag_r <= 1'b0;
      end
    end
  end

  assign O_IRQ = irq_flag_r & irq_en_r;
  // Wake needs no enable so a stopped core still sees the pin
  assign O_WAKE = irq_flag_r;

  // Power state tracking
  always_comb begin
    pwr_nxt = pwr_r;
    case (pwr_r)
      ppc_pkg::PWR_RUN: begin
        if (I_STOP) begin
          pwr_nxt = pd_sel_r ? ppc_pkg::PWR_PART_DOWN
                             : ppc_pkg::PWR_SHALLOW;
        end
      end
      ppc_pkg::PWR_PART_DOWN: begin
        if (!I_STOP) begin
          pwr_nxt = ppc_pkg::PWR_RUN;
        end
      end
      ppc_pkg::PWR_SHALLOW: begin
        if (!I_STOP) begin
          pwr_nxt = ppc_pkg::PWR_RUN;
        end
      end
      default: pwr_nxt = ppc_pkg::PWR_RUN;
    endcase
  end

  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      pwr_r <= ppc_pkg::PWR_RUN;
    end else if (I_CE) begin
      pwr_r <= pwr_nxt;
    end
  end

  // Stop mode select is write-once after reset
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      pd_sel_r <= 1'b0;
      pd_sel_locked_r <= 1'b0;
    end else if (I_CE && cfg_wr_ok && I_PADDR == `PPC_OFS_PWR) begin
      if (!pd_sel_locked_r) begin
        pd_sel_r <= I_PWDATA[`PPC_PW_SEL];
        pd_sel_locked_r <= 1'b1;
      end
    end
  end

  // Recovery flag; recovery wins over an acknowledge
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      pd_flag_r <= 1'b0;
    end else if (I_CE) begin
      if (pwr_r == ppc_pkg::PWR_PART_DOWN && !I_STOP) begin
        pd_flag_r <= 1'b1;
      end else if (pd_ack_wr) begin
        pd_flag_r <= 1'b0;
      end
    end
  end

  assign O_PD_RECOVERED = pd_flag_r;

  // Pad control terms
  always_comb begin
    logic drv;
    drv = 1'b0;
    ctrl_nxt = ctrl_r;
    for (int i = 0; i < PINS; i++) begin
      drv = I_PIN_OWN[i].pin_out | I_PIN_OWN[i].periph_out;
      ctrl_nxt[i].pull_on = pull_en_r[i]
                            & ~drv
                            & ~I_PIN_OWN[i].analog;
      // Pull-down only for a selected interrupt pin
      ctrl_nxt[i].pull_down = pin_sel_r[i] & edge_pol_r[i];
      ctrl_nxt[i].slew_on = slew_en_r[i] & drv;
      ctrl_nxt[i].high_drive = drive_sel_r[i] & drv;
    end
  end

  // Pad controls are held through either stop mode
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      ctrl_r <= '0;
    end else if (I_CE && !holding) begin
      ctrl_r <= ctrl_nxt;
    end
  end

  assign O_PIN_CTRL = ctrl_r;

  // Read data is captured in the setup phase
  always_comb begin
    prdata_nxt = '0;
    rd_err_nxt = ~is_mapped(I_PADDR);
    case (I_PADDR)
      `PPC_OFS_PULL: prdata_nxt = to_word(pull_en_r);
      `PPC_OFS_SLEW: prdata_nxt = to_word(slew_en_r);
      `PPC_OFS_DRIVE: prdata_nxt = to_word(drive_sel_r);
      `PPC_OFS_PINSEL: prdata_nxt = to_word(pin_sel_r);
      `PPC_OFS_EDGE: prdata_nxt = to_word(edge_pol_r);
      `PPC_OFS_IRQSC: begin
        prdata_nxt[`PPC_SC_MODE] = mode_r;
        prdata_nxt[`PPC_SC_IE] = irq_en_r;
        prdata_nxt[`PPC_SC_IF] = irq_flag_r;
      end
      `PPC_OFS_PWR: begin
        prdata_nxt[`PPC_PW_SEL] = pd_sel_r;
        prdata_nxt[`PPC_PW_FLAG] = pd_flag_r;
      end
      `PPC_OFS_PINS: prdata_nxt = to_word(pin_lvl);
      default: prdata_nxt = '0;
    endcase
  end

  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      prdata_r <= '0;
      rd_err_r <= 1'b0;
    end else if (I_CE && setup_ph) begin
      prdata_r <= I_PWRITE ? '0 : prdata_nxt;
      rd_err_r <= rd_err_nxt;
    end
  end

endmodule // ppc_top

// [pkg/ppc_map.svh]
// Register offsets, field positions and reset values of the pin control block
`ifndef PPC_MAP_SVH
`define PPC_MAP_SVH

`define PPC_ADDR_W 5
`define PPC_OFS_PULL 5'h00
`define PPC_OFS_SLEW 5'h04
`define PPC_OFS_DRIVE 5'h08
`define PPC_OFS_PINSEL 5'h0C
`define PPC_OFS_EDGE 5'h10
`define PPC_OFS_IRQSC 5'h14
`define PPC_OFS_PWR 5'h18
`define PPC_OFS_PINS 5'h1C

`define PPC_SC_MODE 0
`define PPC_SC_IE 1
`define PPC_SC_ACK 2
`define PPC_SC_IF 3

`define PPC_PW_SEL 0
`define PPC_PW_ACK 2
`define PPC_PW_FLAG 3

`define PPC_RST_SLEW 1'b1
`define PPC_RST_OFF 1'b0

`endif

// [pkg/ppc_pkg.sv]
// Types shared by the pin control block
package ppc_pkg;

  typedef struct packed {
    logic pull_on;
    logic pull_down;
    logic slew_on;
    logic high_drive;
  } ppc_pin_ctrl_t;

  typedef struct packed {
    logic pin_out;
    logic periph_out;
    logic analog;
  } ppc_pin_own_t;

  typedef enum logic [2:0] {
    PWR_RUN = 3'b001,
    PWR_PART_DOWN = 3'b010,
    PWR_SHALLOW = 3'b100
  } ppc_pwr_t;

endpackage

// [core/ppc_pin_sync.sv]
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module ppc_pin_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  // Pins and filtered level
  input wire logic [WIDTH-1:0] i_pin,
  output logic [WIDTH-1:0] o_level
);

  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;
  logic [WIDTH-1:0] level_r;

  // First stage feeds only the second
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else if (i_ce) begin
      s1_r <= i_pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // A bit moves only once stages two and three agree
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      level_r <= '0;
    end else if (i_ce) begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          level_r[i] <= s3_r[i];
        end
      end
    end
  end

  assign o_level = level_r;

endmodule // ppc_pin_sync

// [dv/ppc_top_monitor.sv]
// Port checker for the pin control block
`timescale 1ns/100ps
`include "ppc_map.svh"
module ppc_top_monitor #(
  parameter int PINS = 8
) (
  // Clock, reset, enable
  input wire logic I_CLK_SYS,
  input wire logic I_NRST,
  input wire logic I_CE,
  // APB request
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [`PPC_ADDR_W-1:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  // Ownership and stop
  input wire ppc_pkg::ppc_pin_own_t [PINS-1:0] I_PIN_OWN,
  input wire logic I_STOP,
  // Outputs watched
  input wire ppc_pkg::ppc_pin_ctrl_t [PINS-1:0] O_PIN_CTRL,
  input wire logic O_IRQ,
  input wire logic O_WAKE,
  input wire logic O_PD_RECOVERED
);
  logic [PINS-1:0] pu, sl, hd, drv, ana;
  logic wr_en, ack_wr, pd_wr;
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      pu[i] = O_PIN_CTRL[i].pull_on;
      sl[i] = O_PIN_CTRL[i].slew_on;
      hd[i] = O_PIN_CTRL[i].high_drive;
      drv[i] = I_PIN_OWN[i].pin_out | I_PIN_OWN[i].periph_out;
      ana[i] = I_PIN_OWN[i].analog;
    end
  end
  assign wr_en = I_PSEL & I_PENABLE & I_PWRITE & I_CE;
  assign ack_wr = wr_en & (I_PADDR == `PPC_OFS_IRQSC) & I_PWDATA[`PPC_SC_ACK];
  assign pd_wr = wr_en & (I_PADDR == `PPC_OFS_PWR) & I_PWDATA[`PPC_PW_ACK];
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (!I_NRST);
  // Stop state lags the request by an edge, so two quiet samples are needed
  sequence s_run;
    I_CE && !I_STOP && !$past(I_STOP);
  endsequence
  AST_PULL_OUT: assert property (s_run |=> (pu & $past(drv)) == '0)
    else $error("pull on while driven");
  AST_PULL_ANA: assert property (s_run |=> (pu & $past(ana)) == '0)
    else $error("pull on while analog");
  AST_SLEW_IN: assert property (s_run |=> (sl & ~$past(drv)) == '0)
    else $error("slew shown on input");
  AST_DRIVE_IN: assert property (s_run |=> (hd & ~$past(drv)) == '0)
    else $error("high drive on input");
  AST_STOP_HOLD: assert property (I_STOP [*3] |-> $stable(O_PIN_CTRL))
    else $error("pad control moved in stop");
  AST_RST_VALS: assert property ($rose(I_NRST) |-> O_PIN_CTRL == '0)
    else $error("outputs wrong after reset");
  AST_PD_ACK: assert property (pd_wr && !I_STOP && !$past(I_STOP)
    |=> !O_PD_RECOVERED) else $error("recovery flag not cleared");
  AST_FLAG_HOLD: assert property ($fell(O_WAKE)
    |-> $past(ack_wr) || $past(ack_wr, 2)) else $error("flag fell unasked");
  COV_IRQ: cover property ($rose(O_IRQ));
  COV_PD: cover property ($rose(O_PD_RECOVERED));
  COV_STOP: cover property (I_STOP [*4]);
endmodule // ppc_top_monitor

bind ppc_top ppc_top_monitor #(.PINS(PINS)) u_ppc_top_monitor (
  .I_CLK_SYS(I_CLK_SYS), .I_NRST(I_NRST), .I_CE(I_CE),
  .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE),
  .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .I_PIN_OWN(I_PIN_OWN),
  .I_STOP(I_STOP), .O_PIN_CTRL(O_PIN_CTRL), .O_IRQ(O_IRQ),
  .O_WAKE(O_WAKE), .O_PD_RECOVERED(O_PD_RECOVERED));

// [dv/ppc_pad_model.sv]
// Board side of the pads: driven, pulled or floating pins
`timescale 1ns/100ps
module ppc_pad_model #(
  parameter int PINS = 8
) (
  // Clock
  input wire logic i_clk,
  // Board drive and pad control
  input wire logic [PINS-1:0] i_drv_en,
  input wire logic [PINS-1:0] i_lvl,
  input wire ppc_pkg::ppc_pin_ctrl_t [PINS-1:0] i_ctrl,
  // Pad levels
  output logic [PINS-1:0] o_pin
);
  logic [PINS-1:0] flt_r = '0;
  // A floating pad wanders instead of holding a lucky value
  always_ff @(posedge i_clk) begin
    flt_r <= ~flt_r;
  end
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      if (i_drv_en[i])
        o_pin[i] = i_lvl[i];
      else if (i_ctrl[i].pull_on)
        o_pin[i] = ~i_ctrl[i].pull_down;
      else
        o_pin[i] = flt_r[i];
    end
  end
endmodule // ppc_pad_model

// [dv/test_ppc_top.sv]
// Self-checking test of the pin control block over APB
`timescale 1ns/100ps
`include "ppc_map.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, e); end end
module test_ppc_top;
  logic clk, nrst, ce, psel, pen, pwr, stop, err, pready, pslverr;
  logic irq, wake, pdr;
  logic [`PPC_ADDR_W-1:0] addr;
  logic [31:0] wdata, rdata, rd;
  ppc_pkg::ppc_pin_own_t [7:0] own;
  ppc_pkg::ppc_pin_ctrl_t [7:0] ctrl;
  logic [7:0] pin, drv_en, lvl, pu_r, sl_r, hd_r, ps_r, es_r;
  int fails, checked;
  ppc_top #(.PINS(8)) u_ppc_top (.I_CLK_SYS(clk), .I_NRST(nrst),
    .I_CE(ce), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
    .I_PADDR(addr), .I_PWDATA(wdata), .O_PRDATA(rdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_PIN_OWN(own),
    .I_PIN(pin), .I_STOP(stop), .O_PIN_CTRL(ctrl), .O_IRQ(irq),
    .O_WAKE(wake), .O_PD_RECOVERED(pdr));
  ppc_pad_model #(.PINS(8)) u_ppc_pad_model (.i_clk(clk),
    .i_drv_en(drv_en), .i_lvl(lvl), .i_ctrl(ctrl), .o_pin(pin));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic report_and_stop();
    if (fails == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [4:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
      fails++;
    rd = rdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    case (a)
      `PPC_OFS_PULL: pu_r = d[7:0];
      `PPC_OFS_SLEW: sl_r = d[7:0];
      `PPC_OFS_DRIVE: hd_r = d[7:0];
      `PPC_OFS_PINSEL: ps_r = d[7:0];
      `PPC_OFS_EDGE: es_r = d[7:0];
      default: ;
    endcase
  endtask
  task automatic chk_rd(input logic [4:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  task automatic chk_ctrl();
    ppc_pkg::ppc_pin_ctrl_t e;
    logic dr;
    for (int i = 0; i < 8; i++) begin
      dr = own[i].pin_out | own[i].periph_out;
      e = {pu_r[i] & ~dr & ~own[i].analog, ps_r[i] & es_r[i],
           sl_r[i] & dr, hd_r[i] & dr};
      `CHK(ctrl[i], e)
    end
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    report_and_stop();
  end
  initial begin
    fails = 0;
    checked = 0;
    {nrst, psel, pen, pwr, stop, addr, wdata} = '0;
    ce = 1'b1;
    own = '0;
    {drv_en, lvl, pu_r, hd_r, ps_r, es_r} = '0;
    sl_r = 8'hFF;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    `CHK(ctrl, '0)
    for (int i = 0; i < 7; i++)
      chk_rd(5'(4 * i), (i == 1) ? 32'hFF : 32'h0);
    apb(1'b0, 5'h02, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    own[0].pin_out <= 1'b1;
    own[1].analog <= 1'b1;
    own[2].periph_out <= 1'b1;
    drv_en <= 8'hE0;
    wr(`PPC_OFS_PULL, 32'hFF);
    wr(`PPC_OFS_DRIVE, 32'h05);
    wr(`PPC_OFS_EDGE, 32'h10);
    wr(`PPC_OFS_PINSEL, 32'h18);
    repeat (8) @(posedge clk);
    chk_ctrl();
    apb(1'b0, `PPC_OFS_PINS, 32'h0);
    `CHK(rd[4:3], 2'b01)
    wr(`PPC_OFS_PINSEL, 32'h0);
    wr(`PPC_OFS_IRQSC, 32'h4);
    for (int p = 1; p >= 0; p--) begin
      // Deselect before a polarity change, or the flip looks like an edge
      wr(`PPC_OFS_PINSEL, 32'h0);
      lvl[5] <= p[0];
      wr(`PPC_OFS_EDGE, 32'(p << 5));
      wr(`PPC_OFS_PINSEL, 32'h20);
      repeat (8) @(posedge clk);
      chk_rd(`PPC_OFS_IRQSC, 32'h0);
      lvl[5] <= ~p[0];
      repeat (8) @(posedge clk);
      chk_rd(`PPC_OFS_IRQSC, 32'h0);
      lvl[5] <= p[0];
      repeat (8) @(posedge clk);
      chk_rd(`PPC_OFS_IRQSC, 32'h8);
      `CHK(irq, 1'b0)
      wr(`PPC_OFS_IRQSC, 32'h4);
      chk_rd(`PPC_OFS_IRQSC, 32'h0);
    end
    lvl[6] <= 1'b1;
    repeat (8) @(posedge clk);
    lvl[6] <= 1'b0;
    repeat (8) @(posedge clk);
    chk_rd(`PPC_OFS_IRQSC, 32'h0);
    lvl[5] <= 1'b1;
    wr(`PPC_OFS_IRQSC, 32'h2);
    lvl[5] <= 1'b0;
    repeat (8) @(posedge clk);
    `CHK({irq, wake}, 2'b11)
    wr(`PPC_OFS_IRQSC, 32'h6);
    `CHK({irq, wake}, 2'b00)
    wr(`PPC_OFS_IRQSC, 32'h1);
    repeat (8) @(posedge clk);
    chk_rd(`PPC_OFS_IRQSC, 32'h9);
    wr(`PPC_OFS_IRQSC, 32'h5);
    chk_rd(`PPC_OFS_IRQSC, 32'h9);
    lvl[5] <= 1'b1;
    repeat (8) @(posedge clk);
    wr(`PPC_OFS_IRQSC, 32'h5);
    chk_rd(`PPC_OFS_IRQSC, 32'h1);
    wr(`PPC_OFS_PWR, 32'h1);
    stop <= 1'b1;
    repeat (4) @(posedge clk);
    apb(1'b1, `PPC_OFS_PULL, 32'h0);
    repeat (2) @(posedge clk);
    chk_ctrl();
    chk_rd(`PPC_OFS_PULL, 32'hFF);
    stop <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK(pdr, 1'b1)
    wr(`PPC_OFS_PWR, 32'h4);
    `CHK(pdr, 1'b0)
    report_and_stop();
  end
endmodule // test_ppc_top
